//--- design/egq_pkg.sv
// Constants, register map and helpers for the egress queue scheduler.
// Assumes one core clock at 40 MHz and a synchronous active-low reset.
package egq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NQ    = 8;
  localparam int NP    = 8;
  localparam int LEN_W = 16;
  localparam int BKT_W = 20;
  localparam int SHP_W = 20;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MAP    = 8'h00;
  localparam logic [7:0] REG_ENA    = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam logic [7:0] REG_DMISC  = 8'h0C;
  localparam logic [7:0] REG_DCAP   = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_WEIGHT = 8'h20;
  localparam logic [7:0] REG_BUCKET = 8'h40;
  localparam logic [7:0] REG_SHAPER = 8'h80;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RST_MAP    = 24'hFAC688;
  localparam logic [7:0]  RST_WEIGHT = 8'h01;
  localparam logic [15:0] RST_DTHR   = 16'h0000;
  localparam logic [7:0]  RST_IFG    = 8'h00;
  localparam logic [15:0] RST_DCAP   = 16'h4000;
  localparam logic [15:0] RST_SFILL  = 16'h0000;
  localparam logic [15:0] RST_STHR   = 16'h0000;
  localparam logic [15:0] RST_SCAP   = 16'hFFFF;

  // ----------------------------------------------------------------
  // Token tick
  // ----------------------------------------------------------------
  localparam int TICK_NS  = 1000;
  localparam int CLK_MHZ  = 40;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;

  // Index of the highest set bit, zero for a zero value
  function automatic logic [3:0] msb_position(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : msb_position

endpackage : egq_pkg

//--- design/egq_shaper.sv
// Token bucket shaper: periodic fill, clamp at capacity, byte charge.
// Assumes tick_i is a one-cycle enable from the core clock domain.
`timescale 1ns/1ps
module egq_shaper #(
  parameter int W = egq_pkg::SHP_W
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        tick_i,
  input  wire logic [15:0] fill_i,
  input  wire logic [15:0] thr_i,
  input  wire logic [15:0] cap_i,
  input  wire logic        chg_i,
  input  wire logic [15:0] bytes_i,
  output logic             ok_o
);

  logic signed [W-1:0] level_q;
  logic signed [W-1:0] level_d;

  always_comb begin
    level_d = level_q;
    if (tick_i) begin
      level_d = level_d + W'(fill_i);
    end
    if (chg_i) begin
      level_d = level_d - W'(bytes_i);
    end
    if (level_d > $signed(W'(cap_i))) begin
      level_d = W'(cap_i);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      level_q <= '0;
    end else begin
      level_q <= level_d;
    end
  end

  // Below threshold blocks new starts only; charge is taken at start
  assign ok_o = level_q >= $signed(W'(thr_i));

endmodule : egq_shaper

//--- design/egq_pick.sv
// Picks the candidate with the largest signed value; lowest index wins
// ties. Purely combinational, no clock.
`timescale 1ns/1ps
module egq_pick #(
  parameter int N = egq_pkg::NQ,
  parameter int W = egq_pkg::BKT_W
) (
  input  wire logic [N-1:0]   cand_i,
  input  wire logic [N*W-1:0] val_i,
  output logic                any_o,
  output logic [2:0]          idx_o
);

  logic signed [W-1:0] best;

  always_comb begin
    any_o = 1'b0;
    idx_o = 3'h0;
    best  = '0;
    for (int j = 0; j < N; j++) begin
      if (cand_i[j] && (!any_o || $signed(val_i[j*W +: W]) > best)) begin
        any_o = 1'b1;
        idx_o = 3'(j);
        best  = val_i[j*W +: W];
      end
    end
  end

endmodule : egq_pick

//--- design/egq_sched.sv
// Egress scheduler for one port: shapers, strict priority, DWRR.
// Assumes queue manager and transmit path share the core clock.
//
// Behaviour
// - Each of the eight queues maps to exactly one of eight priorities.
// - Priority zero is most urgent, seven least urgent.
// - Queue eligible only with a packet and its queue shaper permitting.
// - The queue's priority shaper must also permit.
// - Queue shaper below threshold blocks new starts, not ongoing packets.
// - Queue shaping only when enabled; bucket clamped at capacity.
// - Priority shaper below threshold blocks new starts of that priority.
// - Priority shaping only when enabled; bucket clamped at capacity.
// - Priority needs ready queues, shaper permit, no pause, no halt.
// - Most urgent eligible priority wins, then DWRR picks the queue.
// - DWRR runs only among queues of the same priority.
// - One byte bucket per queue; largest non-empty bucket wins.
// - Sending subtracts the packet length from the chosen bucket.
// - Lowest-numbered bucket under threshold refills every bucket of its group.
// - Refill adds weight shifted by max(0, cell msb minus weight msb).
// - Buckets are clamped to the configured capacity on every cycle.
// - Per-packet overhead is also subtracted on each send.
// - Eight queues per port, fed by the queue manager.
// - Shaper buckets gain a configured amount on each core tick.
// - Disabled queue starts nothing but keeps its packets.
`timescale 1ns/1ps
module egq_sched #(
  parameter int BUFFER_CELL_SIZE = 128,
  parameter int TICK_CYC         = egq_pkg::TICK_CYC
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic [31:0]  reg_wdata_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  output logic      [31:0]  reg_rdata_o,
  input  wire logic [7:0]   q_nonempty_i,
  input  wire logic [127:0] head_len_i,
  input  wire logic [7:0]   prio_pause_i,
  input  wire logic         sched_req_i,
  output logic              sched_ack_o,
  output logic              sched_hit_o,
  output logic      [2:0]   sched_queue_o,
  output logic      [15:0]  sched_len_o
);

  localparam int NQ = egq_pkg::NQ;
  localparam int BW = egq_pkg::BKT_W;
  // Cell size is fixed at build time, so its msb is a constant
  localparam logic [3:0] CELL_MSB =
    egq_pkg::msb_position(16'(BUFFER_CELL_SIZE));
  localparam logic signed [25:0] BKT_MIN = 26'sh3F80000;

  function automatic logic [2:0] prio_of(input logic [23:0] m,
                                         input int j);
    return m[3*j +: 3];
  endfunction : prio_of

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic        [23:0] map_q;
  logic        [7:0]  qshp_en_q;
  logic        [7:0]  pshp_en_q;
  logic        [7:0]  out_dis_q;
  logic        [7:0]  halt_q;
  logic signed [15:0] dthr_q;
  logic        [7:0]  ifg_q;
  logic        [15:0] dcap_q;
  logic        [7:0]  weight_q [NQ];
  logic        [15:0] sfill_q  [16];
  logic        [15:0] sthr_q   [16];
  logic        [15:0] scap_q   [16];

  // ----------------------------------------------------------------
  // State and decision signals
  // ----------------------------------------------------------------
  logic signed [BW-1:0] bkt_q [NQ];
  logic signed [BW-1:0] bkt_d [NQ];
  logic        [NQ*BW-1:0] bkt_flat;
  logic        [15:0]  tick_cnt_q;
  logic                tick;
  logic        [15:0]  shp_ok;
  logic        [15:0]  chg;
  logic        [7:0]   q_ok;
  logic        [7:0]   q_blk;
  logic        [7:0]   p_blk;
  logic        [7:0]   p_ok;
  logic        [7:0]   cand;
  logic        [2:0]   best_p;
  logic                any_p;
  logic                any_q;
  logic        [2:0]   sel;
  logic                grant;
  logic        [15:0]  sel_len;
  logic        [16:0]  chg_amt;
  logic        [2:0]   rq;
  logic                repl_any;
  logic        [3:0]   xs;
  logic signed [25:0]  cap_s;
  logic signed [25:0]  acc;
  logic        [31:0]  rd_val;
  logic        [31:0]  rdata_q;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      map_q     <= egq_pkg::RST_MAP;
      qshp_en_q <= 8'h00;
      pshp_en_q <= 8'h00;
      out_dis_q <= 8'h00;
      halt_q    <= 8'h00;
      dthr_q    <= egq_pkg::RST_DTHR;
      ifg_q     <= egq_pkg::RST_IFG;
      dcap_q    <= egq_pkg::RST_DCAP;
      for (int j = 0; j < NQ; j++) begin
        weight_q[j] <= egq_pkg::RST_WEIGHT;
      end
      for (int s = 0; s < 16; s++) begin
        sfill_q[s] <= egq_pkg::RST_SFILL;
        sthr_q[s]  <= egq_pkg::RST_STHR;
        scap_q[s]  <= egq_pkg::RST_SCAP;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i[7]) begin
        if (reg_addr_i[2]) begin
          sthr_q[reg_addr_i[6:3]] <= reg_wdata_i[15:0];
          scap_q[reg_addr_i[6:3]] <= reg_wdata_i[31:16];
        end else begin
          sfill_q[reg_addr_i[6:3]] <= reg_wdata_i[15:0];
        end
      end else if (reg_addr_i[7:5] == 3'h1) begin
        weight_q[reg_addr_i[4:2]] <= reg_wdata_i[7:0];
      end else begin
        case (reg_addr_i)
          egq_pkg::REG_MAP: begin
            map_q <= reg_wdata_i[23:0];
          end
          egq_pkg::REG_ENA: begin
            qshp_en_q <= reg_wdata_i[7:0];
            pshp_en_q <= reg_wdata_i[15:8];
          end
          egq_pkg::REG_CTRL: begin
            out_dis_q <= reg_wdata_i[7:0];
            halt_q    <= reg_wdata_i[15:8];
          end
          egq_pkg::REG_DMISC: begin
            dthr_q <= reg_wdata_i[15:0];
            ifg_q  <= reg_wdata_i[23:16];
          end
          egq_pkg::REG_DCAP: begin
            dcap_q <= reg_wdata_i[15:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Core tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= 16'h0000;
    end else if (tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  assign tick = tick_cnt_q == 16'(TICK_CYC - 1);

  // ----------------------------------------------------------------
  // Shapers: 0..7 per queue, 8..15 per priority
  // ----------------------------------------------------------------
  for (genvar s = 0; s < 16; s++) begin : g_shp
    egq_shaper u_shp (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (tick),
      .fill_i    (sfill_q[s]),
      .thr_i     (sthr_q[s]),
      .cap_i     (scap_q[s]),
      .chg_i     (chg[s]),
      .bytes_i   (sel_len),
      .ok_o      (shp_ok[s])
    );
  end

  // ----------------------------------------------------------------
  // Eligibility and strict priority
  // ----------------------------------------------------------------
  always_comb begin
    q_blk  = qshp_en_q & ~shp_ok[7:0];
    p_blk  = pshp_en_q & ~shp_ok[15:8];
    p_ok   = 8'h00;
    cand   = 8'h00;
    best_p = 3'h0;
    any_p  = 1'b0;
    for (int j = 0; j < NQ; j++) begin
      // Disabled queues keep packets, they are just never started
      q_ok[j] = q_nonempty_i[j] && !out_dis_q[j] && !q_blk[j];
      if (q_ok[j]) begin
        p_ok[prio_of(map_q, j)] = 1'b1;
      end
    end
    p_ok = p_ok & ~p_blk & ~prio_pause_i & ~halt_q;
    for (int p = 7; p >= 0; p--) begin
      if (p_ok[p]) begin
        best_p = 3'(p);
        any_p  = 1'b1;
      end
    end
    for (int j = 0; j < NQ; j++) begin
      cand[j] = any_p && q_ok[j] && prio_of(map_q, j) == best_p;
    end
  end

  for (genvar j = 0; j < NQ; j++) begin : g_flat
    assign bkt_flat[j*BW +: BW] = bkt_q[j];
  end

  egq_pick u_pick (
    .cand_i (cand),
    .val_i  (bkt_flat),
    .any_o  (any_q),
    .idx_o  (sel)
  );

  assign grant   = sched_req_i && any_q;
  assign sel_len = head_len_i[16*sel +: 16];
  assign chg_amt = 17'(sel_len) + 17'(ifg_q);

  always_comb begin
    for (int s = 0; s < 16; s++) begin
      chg[s] = grant && (s < 8 ? sel == 3'(s) : best_p == 3'(s - 8));
    end
  end

  // ----------------------------------------------------------------
  // DWRR buckets
  // ----------------------------------------------------------------
  assign cap_s = signed'(26'(dcap_q));

  always_comb begin
    rq       = 3'h0;
    repl_any = 1'b0;
    for (int j = NQ - 1; j >= 0; j--) begin
      if (bkt_q[j] < dthr_q) begin
        rq       = 3'(j);
        repl_any = 1'b1;
      end
    end
    if (CELL_MSB > egq_pkg::msb_position(16'(weight_q[rq]))) begin
      xs = CELL_MSB - egq_pkg::msb_position(16'(weight_q[rq]));
    end else begin
      xs = 4'h0;
    end
    acc = '0;
    for (int j = 0; j < NQ; j++) begin
      acc = 26'(bkt_q[j]);
      if (grant && sel == 3'(j)) begin
        acc = acc - signed'(26'(chg_amt));
      end
      if (repl_any && prio_of(map_q, j) == prio_of(map_q, int'(rq))) begin
        acc = acc + signed'(26'(weight_q[j]) << xs);
      end
      if (acc > cap_s) begin
        acc = cap_s;
      end
      if (acc < BKT_MIN) begin
        acc = BKT_MIN;
      end
      bkt_d[j] = acc[BW-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int j = 0; j < NQ; j++) begin
        bkt_q[j] <= '0;
      end
    end else begin
      for (int j = 0; j < NQ; j++) begin
        bkt_q[j] <= bkt_d[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit answer, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sched_ack_o   <= 1'b0;
      sched_hit_o   <= 1'b0;
      sched_queue_o <= 3'h0;
      sched_len_o   <= 16'h0000;
    end else begin
      sched_ack_o <= sched_req_i;
      sched_hit_o <= grant;
      if (grant) begin
        sched_queue_o <= sel;
        sched_len_o   <= sel_len;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_addr_i[7]) begin
      rd_val = reg_addr_i[2] ?
        {scap_q[reg_addr_i[6:3]], sthr_q[reg_addr_i[6:3]]} :
        {16'h0000, sfill_q[reg_addr_i[6:3]]};
    end else if (reg_addr_i[7:5] == 3'h1) begin
      rd_val = {24'h000000, weight_q[reg_addr_i[4:2]]};
    end else if (reg_addr_i[7:5] == 3'h2) begin
      rd_val = 32'(bkt_q[reg_addr_i[4:2]]);
    end else begin
      case (reg_addr_i)
        egq_pkg::REG_MAP:    rd_val = {8'h00, map_q};
        egq_pkg::REG_ENA:    rd_val = {16'h0000, pshp_en_q, qshp_en_q};
        egq_pkg::REG_CTRL:   rd_val = {16'h0000, halt_q, out_dis_q};
        egq_pkg::REG_DMISC:  rd_val = {8'h00, ifg_q, dthr_q};
        egq_pkg::REG_DCAP:   rd_val = {16'h0000, dcap_q};
        egq_pkg::REG_STATUS: rd_val = {12'h000, any_p, best_p, p_ok, q_ok};
        default:             rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd_i ? rd_val : 32'h0000_0000;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic               lower_ok;
  logic               bigger;
  logic               over_cap;
  logic [7:0]         q_pblk;
  logic signed [BW-1:0] sel_bkt;
  logic signed [BW-1:0] rq_bkt;

  always_comb begin
    lower_ok = |(p_ok & ((8'h01 << best_p) - 8'h01));
    bigger   = 1'b0;
    over_cap = 1'b0;
    for (int j = 0; j < NQ; j++) begin
      q_pblk[j] = p_blk[prio_of(map_q, j)];
      if (cand[j] && bkt_q[j] > bkt_q[sel]) begin
        bigger = 1'b1;
      end
      if (26'(bkt_q[j]) > cap_s) begin
        over_cap = 1'b1;
      end
    end
    sel_bkt = bkt_q[sel];
    rq_bkt  = bkt_q[rq];
  end

  property p_ack;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sched_req_i |=> sched_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");

  property p_empty;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (sched_req_i && q_nonempty_i == 8'h00) |=> !sched_hit_o;
  endproperty
  a_empty: assert property (p_empty) else $error("empty port granted");

  property p_dis;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sched_hit_o |-> (($past(out_dis_q) >> sched_queue_o) & 8'h01) == 8'h00;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled queue started");

  property p_qshp;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sched_hit_o |-> (($past(q_blk) >> sched_queue_o) & 8'h01) == 8'h00;
  endproperty
  a_qshp: assert property (p_qshp) else $error("queue shaper ignored");

  property p_pshp;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sched_hit_o |-> (($past(q_pblk) >> sched_queue_o) & 8'h01) == 8'h00;
  endproperty
  a_pshp: assert property (p_pshp) else $error("prio shaper ignored");

  property p_strict;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    grant |-> !lower_ok && prio_of(map_q, int'(sel)) == best_p;
  endproperty
  a_strict: assert property (p_strict) else $error("wrong priority");

  property p_largest;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    grant |-> !bigger;
  endproperty
  a_largest: assert property (p_largest) else $error("not largest bucket");

  property p_cap;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $stable(dcap_q) |-> !over_cap;
  endproperty
  a_cap: assert property (p_cap) else $error("bucket above cap");

  property p_charge;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (grant && !repl_any && 26'(sel_bkt) - signed'(26'(chg_amt)) > BKT_MIN) |=>
      bkt_q[sched_queue_o] == $past(sel_bkt) - BW'($past(chg_amt));
  endproperty
  a_charge: assert property (p_charge) else $error("bad charge");

  property p_repl;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (repl_any && !grant && weight_q[rq] != 8'h00) |=>
      (bkt_q[$past(rq)] > $past(rq_bkt) || 26'(bkt_q[$past(rq)]) == cap_s);
  endproperty
  a_repl: assert property (p_repl) else $error("no refill");

  c_grant: cover property (@(posedge ref_clk_i) grant);
  c_refill: cover property (@(posedge ref_clk_i) repl_any && grant);
  c_miss: cover property (@(posedge ref_clk_i) sched_req_i && !any_q);
  c_low: cover property (@(posedge ref_clk_i) grant && best_p != 3'h0);

endmodule : egq_sched

//--- bench/egq_qm_model.sv
// Queue manager model: per-queue packet counts and head lengths.
// Assumes grants arrive on the scheduler's registered hit and queue.
`timescale 1ns/1ps
module egq_qm_model (
  input  wire logic         ref_clk_i,
  input  wire logic         hit_i,
  input  wire logic [2:0]   queue_i,
  output logic      [7:0]   q_nonempty_o,
  output logic      [127:0] head_len_o
);
  logic [7:0]  cnt [8] = '{default: 8'h00};
  logic [15:0] len [8] = '{default: 16'h0000};
  // Empty queues show an inverted length, never a stale valid one
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      q_nonempty_o[q]      = (cnt[q] != 8'h00);
      head_len_o[16*q+:16] = (cnt[q] != 8'h00) ? len[q] : ~len[q];
    end
  end
  // Pop one packet per grant, ahead of the next request
  always @(posedge ref_clk_i) begin
    if (hit_i && cnt[queue_i] != 8'h00) begin
      cnt[queue_i] <= cnt[queue_i] - 8'h01;
    end
  end
  task automatic load(input logic [2:0] q, input logic [7:0] n,
                      input logic [15:0] l);
    cnt[q] <= n;
    len[q] <= l;
  endtask : load
endmodule : egq_qm_model

//--- bench/tb_egress_queue_scheduler.sv
// Testbench for the egress scheduler: register and request sequences.
// Assumes the queue manager model pops one packet per grant.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  error_cnt++; $display("unexpected at %0t: got %0h exp %0h", \
  $time, g, e); end end
module tb_egress_queue_scheduler;
  logic         ref_clk_i, rst_n_i, reg_wr, reg_rd, req, ack, hit;
  logic [7:0]   reg_addr, pause, nonempty;
  logic [31:0]  reg_wdata, rdata, d;
  logic [127:0] head_len;
  logic [2:0]   queue;
  logic [15:0]  len;
  int           error_cnt, checks_done;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  egq_sched #(.BUFFER_CELL_SIZE(128), .TICK_CYC(4)) egq_sched_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .q_nonempty_i(nonempty), .head_len_i(head_len),
    .prio_pause_i(pause), .sched_req_i(req), .sched_ack_o(ack),
    .sched_hit_o(hit), .sched_queue_o(queue), .sched_len_o(len));
  egq_qm_model egq_qm_model_i (.ref_clk_i(ref_clk_i), .hit_i(hit),
    .queue_i(queue), .q_nonempty_o(nonempty), .head_len_o(head_len));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd   <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // Ack and hit stand one cycle only, so they are looked at right away
  task automatic ask(input logic exp_hit, input logic [2:0] exp_q);
    @(posedge ref_clk_i);
    req <= 1'b1;
    @(posedge ref_clk_i);
    req <= 1'b0;
    #1;
    `CHK(ack, 1'b1)
    `CHK(hit, exp_hit)
    if (exp_hit) `CHK(queue, exp_q)
    @(posedge ref_clk_i);
    #1;
  endtask : ask
  task automatic finish_test();
    $display("counts: %0d checks, %0d mismatches", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Whole sequence needs about a hundred cycles; this bound is generous
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    error_cnt++;
    finish_test();
  end
  initial begin
    rst_n_i   = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    req       = 1'b0;
    pause     = 8'h00;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(egq_pkg::REG_MAP, d);
    `CHK(d, {8'h00, egq_pkg::RST_MAP})
    rd(egq_pkg::REG_WEIGHT + 8'h1C, d);
    `CHK(d, {24'h0, egq_pkg::RST_WEIGHT})
    rd(egq_pkg::REG_DCAP, d);
    `CHK(d, {16'h0, egq_pkg::RST_DCAP})
    rd(8'h18, d);
    `CHK(d, 32'h0)
    $display("test reset done");
    egq_qm_model_i.load(3'h3, 8'h01, 16'h0040);
    egq_qm_model_i.load(3'h5, 8'h01, 16'h0050);
    ask(1'h1, 3'h3);
    `CHK(len, 16'h0040)
    egq_qm_model_i.load(3'h3, 8'h01, 16'h0040);
    @(posedge ref_clk_i) pause <= 8'h08;
    ask(1'h1, 3'h5);
    @(posedge ref_clk_i) pause <= 8'h00;
    egq_qm_model_i.load(3'h5, 8'h01, 16'h0050);
    wr(egq_pkg::REG_CTRL, 32'h0000_2800);
    ask(1'h0, 3'h0);
    wr(egq_pkg::REG_CTRL, 32'h0000_0008);
    ask(1'h1, 3'h5);
    wr(egq_pkg::REG_CTRL, 32'h0);
    ask(1'h1, 3'h3);
    ask(1'h0, 3'h0);
    $display("test priority done");
    // Queue 1 moves to priority 0 and shares it with queue 0
    wr(egq_pkg::REG_MAP, 32'h00FA_C680);
    wr(egq_pkg::REG_DMISC, 32'h0004_0000);
    wr(egq_pkg::REG_DCAP, 32'h0000_0064);
    egq_qm_model_i.load(3'h0, 8'h02, 16'h0064);
    egq_qm_model_i.load(3'h1, 8'h02, 16'h003C);
    ask(1'h1, 3'h0);
    repeat (4) @(posedge ref_clk_i);
    // Grant 100 plus overhead 4, then one refill of 1 << (7 - 0)
    rd(egq_pkg::REG_BUCKET, d);
    `CHK(d, 32'h0000_0018)
    rd(egq_pkg::REG_BUCKET + 8'h04, d);
    `CHK(d, 32'h0000_0064)
    rd(egq_pkg::REG_BUCKET + 8'h0C, d);
    `CHK(d, 32'h0)
    ask(1'h1, 3'h1);
    egq_qm_model_i.load(3'h0, 8'h00, 16'h0000);
    egq_qm_model_i.load(3'h1, 8'h00, 16'h0000);
    $display("test dwrr done");
    egq_qm_model_i.load(3'h2, 8'h04, 16'h0032);
    wr(egq_pkg::REG_SHAPER + 8'h14, 32'hFFFF_0001);
    ask(1'h1, 3'h2);
    wr(egq_pkg::REG_ENA, 32'h0000_0004);
    ask(1'h0, 3'h0);
    wr(egq_pkg::REG_SHAPER + 8'h10, 32'h0000_0100);
    repeat (20) @(posedge ref_clk_i);
    ask(1'h1, 3'h2);
    wr(egq_pkg::REG_SHAPER + 8'h54, 32'hFFFF_0001);
    wr(egq_pkg::REG_ENA, 32'h0000_0404);
    ask(1'h0, 3'h0);
    wr(egq_pkg::REG_ENA, 32'h0000_0004);
    ask(1'h1, 3'h2);
    $display("test shaper done");
    finish_test();
  end
endmodule : tb_egress_queue_scheduler
